/* hdl/cpe_map.vh */
// Constants for the command parser error classifier: error codes,
// character codes, limits and parameter data types. Definitions only.
`ifndef CPE_MAP_VH
`define CPE_MAP_VH
`define CPE_E_CMD 16'hFF9C
`define CPE_E_BADCHAR 16'hFF9B
`define CPE_E_SYNTAX 16'hFF9A
`define CPE_E_SEP 16'hFF99
`define CPE_E_DTYPE 16'hFF98
`define CPE_E_GET 16'hFF97
`define CPE_E_PEXTRA 16'hFF94
`define CPE_E_PMISS 16'hFF93
`define CPE_E_HDR 16'hFF92
`define CPE_E_HSEP 16'hFF91
`define CPE_E_HLONG 16'hFF90
`define CPE_E_HUNDEF 16'hFF8F
`define CPE_E_HSUF 16'hFF8E
`define CPE_E_NUM 16'hFF88
`define CPE_E_NCHAR 16'hFF87
`define CPE_E_EXPBIG 16'hFF85
`define CPE_E_DIGITS 16'hFF84
`define CPE_E_NUMNA 16'hFF80
`define CPE_E_SUFBAD 16'hFF7D
`define CPE_E_SUFLONG 16'hFF7A
`define CPE_E_SUFNA 16'hFF76
`define CPE_E_CBAD 16'hFF73
`define CPE_E_CLONG 16'hFF70
`define CPE_E_CNA 16'hFF6C
`define CPE_E_SBAD 16'hFF69
`define CPE_E_SNA 16'hFF62
`define CPE_E_BBAD 16'hFF5F
`define CPE_E_BNA 16'hFF58
`define CPE_E_EXPR 16'hFF56
`define CPE_E_XBAD 16'hFF55
`define CPE_MNEM_MAX 8'h0C
`define CPE_MANT_MAX 9'h0FF
`define CPE_EXP_MAX 16'h7D00
`define CPE_CH_SEMI 8'h3B
`define CPE_CH_COLON 8'h3A
`define CPE_CH_COMMA 8'h2C
`define CPE_CH_SPACE 8'h20
`define CPE_CH_STAR 8'h2A
`define CPE_CH_QUOTE 8'h22
`define CPE_CH_HASH 8'h23
`define CPE_CH_LPAR 8'h28
`define CPE_CH_RPAR 8'h29
`define CPE_CH_LF 8'h0A
`define CPE_CH_DOT 8'h2E
`define CPE_CH_PLUS 8'h2B
`define CPE_CH_MINUS 8'h2D
`define CPE_CH_E 8'h45
`define CPE_CH_AMP 8'h26
`define CPE_CH_Q 8'h3F
`define CPE_T_NONE 3'h0
`define CPE_T_NUM 3'h1
`define CPE_T_CHR 3'h2
`define CPE_T_STR 3'h3
`define CPE_T_BLK 3'h4
`define CPE_T_EXPR 3'h5
`endif

/* hdl/cpe_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module cpe_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  reg outv_reg;
  wire push;
  wire pop;
  wire load;

  // The output word lives in a register, so one slot sits outside mem.
  assign load = (cnt_reg != {(AW+1){1'b0}}) && (!outv_reg || out_ready);
  assign pop = outv_reg && out_ready;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign out_valid = outv_reg;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
    if (load) begin
      out_data <= mem[rd_reg];
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      outv_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (load) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (load) begin
        outv_reg <= 1'b1;
      end else if (pop) begin
        outv_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/cpe_classifier.v */
// Command parser error classifier: watches a byte stream of program
// messages plus parser context and queues at most one signed error code per cycle:
// trig_in in a message, else parse_fault, else the byte taken.
// Assumes the header lookup (defined, parameter limits, accepted data
// types) is supplied by the command table on the same clock.
`include "cpe_map.vh"
`timescale 1ns/1ns
`default_nettype none
module cpe_classifier #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_end,
  input wire trig_in,
  input wire hdr_defined,
  input wire [3:0] hdr_min_par,
  input wire [3:0] hdr_max_par,
  input wire [5:0] hdr_types_ok,
  input wire hdr_suffix_ok,
  input wire parse_fault,
  output wire rx_ready,
  output wire [15:0] err_code,
  output wire err_valid,
  input wire err_ready,
  output wire [3:0] par_count,
  output wire in_message
);
  localparam ST_IDLE = 4'h0;
  localparam ST_HDR = 4'h1;
  localparam ST_PSEP = 4'h2;
  localparam ST_NUM = 4'h3;
  localparam ST_EXP = 4'h4;
  localparam ST_SUF = 4'h5;
  localparam ST_CHR = 4'h6;
  localparam ST_STR = 4'h7;
  localparam ST_BLKD = 4'h8;
  localparam ST_BLKN = 4'h9;
  localparam ST_BLKB = 4'hA;
  localparam ST_EXPR = 4'hB;
  localparam ST_SKIP = 4'hC;
  localparam ST_AFTER = 4'hD;

  reg [3:0] st_reg, st_next;
  reg [7:0] len_reg, len_next;
  reg [8:0] mant_reg, mant_next;
  reg [15:0] expv_reg, expv_next;
  reg [3:0] par_reg, par_next;
  reg [3:0] depth_reg, depth_next;
  reg [3:0] bdig_reg, bdig_next;
  reg [31:0] blen_reg, blen_next;
  reg colon_reg, colon_next;
  reg msg_reg, msg_next;
  reg [15:0] code_reg, code_next;
  reg code_v_reg, code_v_next;
  reg [2:0] ty;
  reg [19:0] exp_wide;
  wire [7:0] c;
  wire take;
  wire fifo_in_ready;

  assign c = rx_byte;
  // Back-pressure: the stream stalls while a code waits for queue room.
  assign rx_ready = !code_v_reg || fifo_in_ready;
  assign take = rx_valid && rx_ready;
  assign par_count = par_reg;
  assign in_message = msg_reg;

  function is_digit;
    input [7:0] ch;
    begin
      is_digit = (ch >= 8'h30) && (ch <= 8'h39);
    end
  endfunction

  function is_alpha;
    input [7:0] ch;
    begin
      is_alpha = ((ch | 8'h20) >= 8'h61) && ((ch | 8'h20) <= 8'h7A);
    end
  endfunction

  function is_white;
    input [7:0] ch;
    begin
      is_white = (ch == `CPE_CH_SPACE) || (ch == 8'h09);
    end
  endfunction

  function is_term;
    input [7:0] ch;
    begin
      is_term = (ch == `CPE_CH_SEMI) || (ch == `CPE_CH_LF);
    end
  endfunction

  // Data type a parameter starts with.
  always @* begin
    ty = `CPE_T_NONE;
    if (is_digit(c) || c == `CPE_CH_PLUS || c == `CPE_CH_MINUS ||
        c == `CPE_CH_DOT || c == `CPE_CH_AMP) begin
      ty = `CPE_T_NUM;
    end else if (is_alpha(c)) begin
      ty = `CPE_T_CHR;
    end else if (c == `CPE_CH_QUOTE || c == 8'h27) begin
      ty = `CPE_T_STR;
    end else if (c == `CPE_CH_HASH) begin
      ty = `CPE_T_BLK;
    end else if (c == `CPE_CH_LPAR) begin
      ty = `CPE_T_EXPR;
    end
  end

  always @* begin
    st_next = st_reg;
    len_next = len_reg;
    mant_next = mant_reg;
    expv_next = expv_reg;
    par_next = par_reg;
    depth_next = depth_reg;
    bdig_next = bdig_reg;
    blen_next = blen_reg;
    colon_next = colon_reg;
    msg_next = msg_reg;
    code_next = code_reg;
    code_v_next = 1'b0;
    exp_wide = 20'h00000;
    if (trig_in && msg_reg) begin
      code_next = `CPE_E_GET;
      code_v_next = 1'b1;
    end else if (parse_fault) begin
      code_next = `CPE_E_CMD;
      code_v_next = 1'b1;
    end else if (take) begin
      msg_next = !(rx_end || c == `CPE_CH_LF);
      case (st_reg)
        ST_IDLE, ST_AFTER: begin
          colon_next = 1'b0;
          par_next = 4'h0;
          len_next = 8'h00;
          if (is_alpha(c) || c == `CPE_CH_STAR || c == `CPE_CH_COLON) begin
            st_next = ST_HDR;
            len_next = is_alpha(c) ? 8'h01 : 8'h00;
          end else if (c == `CPE_CH_SEMI && st_reg == ST_AFTER &&
                       colon_reg) begin
            code_next = `CPE_E_SEP;
            code_v_next = 1'b1;
          end else if (!is_white(c) && !is_term(c)) begin
            code_next = `CPE_E_HSUF;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_HDR: begin
          if (is_alpha(c) || is_digit(c) || c == `CPE_CH_Q) begin
            len_next = len_reg + 8'h01;
            if (len_reg == `CPE_MNEM_MAX) begin
              code_next = `CPE_E_HLONG;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else if (c == `CPE_CH_COLON) begin
            if (len_reg == 8'h00) begin
              code_next = `CPE_E_HDR;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
            len_next = 8'h00;
          end else if (c == `CPE_CH_SEMI && colon_reg &&
                       len_reg == 8'h00) begin
            // A colon straight before a semicolon is a separator fault.
            code_next = `CPE_E_SEP;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end else if (is_white(c) || is_term(c) || rx_end) begin
            if (!hdr_defined) begin
              code_next = `CPE_E_HUNDEF;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end else if (is_white(c)) begin
              st_next = ST_PSEP;
            end else if (hdr_min_par != 4'h0) begin
              code_next = `CPE_E_PMISS;
              code_v_next = 1'b1;
              st_next = ST_IDLE;
            end else begin
              st_next = ST_IDLE;
            end
            if (!is_white(c) && !is_term(c) && hdr_defined) begin
              code_next = `CPE_E_HSEP;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else begin
            code_next = `CPE_E_HSEP;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_PSEP: begin
          len_next = 8'h00;
          mant_next = 9'h000;
          expv_next = 16'h0000;
          depth_next = 4'h0;
          bdig_next = 4'h0;
          blen_next = 32'h0;
          if (is_white(c)) begin
            st_next = ST_PSEP;
          end else if (is_term(c) || rx_end) begin
            st_next = ST_IDLE;
            if (par_reg < hdr_min_par) begin
              code_next = `CPE_E_PMISS;
              code_v_next = 1'b1;
            end
          end else if (par_reg == hdr_max_par) begin
            code_next = `CPE_E_PEXTRA;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end else if (ty == `CPE_T_NONE) begin
            code_next = `CPE_E_SYNTAX;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end else if (!hdr_types_ok[ty]) begin
            st_next = ST_SKIP;
            code_v_next = 1'b1;
            case (ty)
              `CPE_T_NUM: code_next = `CPE_E_NUMNA;
              `CPE_T_CHR: code_next = `CPE_E_CNA;
              `CPE_T_STR: code_next = `CPE_E_SNA;
              `CPE_T_BLK: code_next = `CPE_E_BNA;
              default: code_next = `CPE_E_DTYPE;
            endcase
          end else begin
            par_next = par_reg + 4'h1;
            case (ty)
              `CPE_T_NUM: begin
                st_next = ST_NUM;
                mant_next = {8'h00, is_digit(c) && c != 8'h30};
              end
              `CPE_T_CHR: begin
                st_next = ST_CHR;
                len_next = 8'h01;
              end
              `CPE_T_STR: st_next = ST_STR;
              `CPE_T_BLK: st_next = ST_BLKD;
              `CPE_T_EXPR: begin
                st_next = ST_EXPR;
                depth_next = 4'h1;
              end
              default: st_next = ST_SKIP;
            endcase
          end
        end
        ST_NUM: begin
          if (is_digit(c)) begin
            // Leading zeros never count toward the mantissa length.
            if (mant_reg != 9'h000 || c != 8'h30) begin
              mant_next = mant_reg + 9'h001;
            end
            if (mant_reg == `CPE_MANT_MAX) begin
              code_next = `CPE_E_DIGITS;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else if ((c | 8'h20) == (`CPE_CH_E | 8'h20)) begin
            st_next = ST_EXP;
          end else if (c == `CPE_CH_DOT || c == `CPE_CH_PLUS ||
                       c == `CPE_CH_MINUS) begin
            st_next = ST_NUM;
          end else if (is_white(c)) begin
            st_next = ST_SUF;
            len_next = 8'h00;
          end else if (c == `CPE_CH_COMMA) begin
            st_next = ST_PSEP;
          end else if (is_term(c)) begin
            st_next = ST_AFTER;
          end else if (is_alpha(c)) begin
            st_next = ST_SUF;
            len_next = 8'h01;
            if (!hdr_suffix_ok) begin
              code_next = `CPE_E_SUFNA;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else begin
            code_next = `CPE_E_NCHAR;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_EXP: begin
          if (is_digit(c)) begin
            // Four spare bits keep ten times the limit from wrapping.
            exp_wide = ({4'h0, expv_reg} << 3) + ({4'h0, expv_reg} << 1) +
              {12'h000, c - 8'h30};
            expv_next = exp_wide[15:0];
            if (exp_wide > {4'h0, `CPE_EXP_MAX}) begin
              code_next = `CPE_E_EXPBIG;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else if (c == `CPE_CH_PLUS || c == `CPE_CH_MINUS) begin
            st_next = ST_EXP;
          end else if (c == `CPE_CH_COMMA) begin
            st_next = ST_PSEP;
          end else if (is_term(c) || is_white(c)) begin
            st_next = ST_AFTER;
          end else begin
            code_next = `CPE_E_NCHAR;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_SUF: begin
          if (is_alpha(c) || c == 8'h2F || c == `CPE_CH_DOT) begin
            len_next = len_reg + 8'h01;
            if (len_reg == 8'h00 && !hdr_suffix_ok) begin
              code_next = `CPE_E_SUFNA;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end else if (len_reg == `CPE_MNEM_MAX) begin
              code_next = `CPE_E_SUFLONG;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else if (c == `CPE_CH_COMMA) begin
            st_next = ST_PSEP;
          end else if (is_term(c)) begin
            st_next = ST_AFTER;
          end else if (!is_white(c)) begin
            code_next = `CPE_E_SUFBAD;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_CHR: begin
          if (is_alpha(c) || is_digit(c) || c == 8'h5F) begin
            len_next = len_reg + 8'h01;
            if (len_reg == `CPE_MNEM_MAX) begin
              code_next = `CPE_E_CLONG;
              code_v_next = 1'b1;
              st_next = ST_SKIP;
            end
          end else if (c == `CPE_CH_COMMA) begin
            st_next = ST_PSEP;
          end else if (is_term(c) || is_white(c)) begin
            st_next = ST_AFTER;
          end else begin
            code_next = `CPE_E_CBAD;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_STR: begin
          if (rx_end) begin
            code_next = `CPE_E_SBAD;
            code_v_next = 1'b1;
            st_next = ST_IDLE;
          end else if (c == `CPE_CH_QUOTE || c == 8'h27) begin
            st_next = ST_CHR;
            len_next = 8'h00;
          end
        end
        ST_BLKD: begin
          if (is_digit(c) && c != 8'h30) begin
            bdig_next = c[3:0];
            st_next = ST_BLKN;
          end else if (c == 8'h30) begin
            st_next = ST_SKIP;
          end else begin
            code_next = `CPE_E_BBAD;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_BLKN: begin
          if (!is_digit(c) || rx_end) begin
            code_next = `CPE_E_BBAD;
            code_v_next = 1'b1;
            st_next = ST_IDLE;
          end else begin
            blen_next = (blen_reg << 3) + (blen_reg << 1) +
              {28'h0, c[3:0]};
            bdig_next = bdig_reg - 4'h1;
            if (bdig_reg == 4'h1) begin
              st_next = ST_BLKB;
            end
          end
        end
        ST_BLKB: begin
          if (blen_reg == 32'h0) begin
            st_next = (c == `CPE_CH_COMMA) ? ST_PSEP : ST_AFTER;
          end else begin
            blen_next = blen_reg - 32'h1;
            if (rx_end && blen_reg != 32'h1) begin
              code_next = `CPE_E_BBAD;
              code_v_next = 1'b1;
              st_next = ST_IDLE;
            end
          end
        end
        ST_EXPR: begin
          if (c == `CPE_CH_LPAR) begin
            depth_next = depth_reg + 4'h1;
          end else if (c == `CPE_CH_RPAR) begin
            depth_next = depth_reg - 4'h1;
            if (depth_reg == 4'h1) begin
              st_next = ST_CHR;
              len_next = 8'h00;
            end
          end else if (is_term(c) || rx_end) begin
            code_next = `CPE_E_XBAD;
            code_v_next = 1'b1;
            st_next = ST_IDLE;
          end else if (c < 8'h20 || c == `CPE_CH_QUOTE) begin
            code_next = `CPE_E_BADCHAR;
            code_v_next = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_SKIP: begin
          if (is_term(c) || rx_end) begin
            st_next = ST_IDLE;
          end
        end
        default: begin
          st_next = ST_IDLE;
          code_next = `CPE_E_CMD;
          code_v_next = 1'b1;
        end
      endcase
      if (st_reg == ST_HDR && c == `CPE_CH_COLON) begin
        colon_next = 1'b1;
      end
      // A message end resynchronises unless a trig_in or parse_fault code wins that cycle, even after a fault on it,
      // so that the next message is never skipped.
      if (rx_end || c == `CPE_CH_LF) begin
        st_next = ST_IDLE;
        par_next = 4'h0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= ST_IDLE;
      len_reg <= 8'h00;
      mant_reg <= 9'h000;
      expv_reg <= 16'h0000;
      par_reg <= 4'h0;
      depth_reg <= 4'h0;
      bdig_reg <= 4'h0;
      blen_reg <= 32'h0;
      colon_reg <= 1'b0;
      msg_reg <= 1'b0;
      code_reg <= 16'h0000;
      code_v_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      len_reg <= len_next;
      mant_reg <= mant_next;
      expv_reg <= expv_next;
      par_reg <= par_next;
      depth_reg <= depth_next;
      bdig_reg <= bdig_next;
      blen_reg <= blen_next;
      colon_reg <= colon_next;
      msg_reg <= msg_next;
      if (!code_v_reg || fifo_in_ready) begin
        code_reg <= code_next;
        code_v_reg <= code_v_next;
      end
    end
  end

  cpe_fifo #(
    .WIDTH(16),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_queue (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_data(code_reg),
    .in_valid(code_v_reg),
    .in_ready(fifo_in_ready),
    .out_data(err_code),
    .out_valid(err_valid),
    .out_ready(err_ready)
  );
endmodule
`default_nettype wire

/* test/cpe_classifier_assertions.sv */
// Port-level checks for the error classifier, bound into every instance.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module cpe_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic trig_in,
  input wire logic hdr_defined,
  input wire logic [3:0] hdr_min_par,
  input wire logic [3:0] hdr_max_par,
  input wire logic [5:0] hdr_types_ok,
  input wire logic hdr_suffix_ok,
  input wire logic parse_fault,
  input wire logic rx_ready,
  input wire logic [15:0] err_code,
  input wire logic err_valid,
  input wire logic err_ready,
  input wire logic [3:0] par_count,
  input wire logic in_message
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  reset_state_a: assert property (disable iff (1'h0)
    !resetn |=> !err_valid && par_count == 4'h0 && !in_message && rx_ready)
    else $error("state not cleared by reset");
  head_hold_a: assert property (
    err_valid && !err_ready |=> err_valid && $stable(err_code))
    else $error("queue head changed without a pop");
  pop_only_a: assert property ($fell(err_valid) |-> $past(err_ready))
    else $error("queue emptied without a pop");
  accept_empty_a: assert property (!err_valid |-> rx_ready)
    else $error("byte refused while queue empty");
  code_family_a: assert property (err_valid |-> err_code[15:8] == 8'hFF)
    else $error("error code not negative");
  trig_code_a: assert property (
    trig_in && in_message && !err_valid && !rx_valid && !$past(rx_valid)
    |-> ##[1:4] (err_valid && err_code == 16'hFF97))
    else $error("trigger inside message not reported");
  fault_code_a: assert property (
    parse_fault && !trig_in && !err_valid && !rx_valid && !$past(rx_valid)
    |-> ##[1:4] (err_valid && err_code == 16'hFF9C))
    else $error("generic command fault not reported");
  msg_end_a: assert property (rx_valid && rx_ready && rx_end |=> !in_message)
    else $error("message still open after end byte");
  msg_start_a: assert property (
    rx_valid && rx_ready && !rx_end && rx_byte != 8'h0A && !trig_in
    |=> in_message)
    else $error("message not opened by a byte");
  count_clear_a: assert property (
    rx_valid && rx_ready && rx_end |=> par_count == 4'h0)
    else $error("parameter count kept across messages");
  cov_undef_c: cover property (err_valid && err_code == 16'hFF8F);
  cov_trig_c: cover property (err_valid && err_code == 16'hFF97);
  cov_full_c: cover property (!rx_ready);
endmodule
bind cpe_classifier cpe_checker u_chk (.*);
`default_nettype wire

/* test/cpe_ctrl_model.sv */
// Behavioural bus controller that sends program message bytes.
// Assumes the classifier takes a byte at a rising edge with rx_ready high.
`timescale 1ns/1ns
`default_nettype none
module cpe_ctrl_model (
  input wire logic sys_clk,
  input wire logic rx_ready,
  output var logic [7:0] rx_byte,
  output var logic rx_valid,
  output var logic rx_end
);
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'h0;
    rx_end = 1'h0;
  end
  // Each byte is held until taken; afterwards the lane shows the inverse
  // of the last byte so that no stale value can be relied on.
  task send_msg(input string m, input logic fin);
    int i;
    logic ok;
    for (i = 0; i < m.len(); i++) begin
      @(negedge sys_clk);
      rx_byte = m[i];
      rx_valid = 1'h1;
      rx_end = fin && (i == m.len() - 1);
      forever begin
        #1 ok = rx_ready;
        @(posedge sys_clk);
        if (ok === 1'h1) break;
      end
    end
    @(negedge sys_clk);
    rx_valid = 1'h0;
    rx_end = 1'h0;
    rx_byte = ~rx_byte;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the error classifier: a table of messages,
// then trigger, generic fault, mantissa limit and a full queue.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {string m; logic d; logic [5:0] ty; logic s;
    logic [15:0] c;} cpe_row_t;
  logic sys_clk, resetn, rx_valid, rx_end, trig_in, hdr_defined;
  logic hdr_suffix_ok, parse_fault, rx_ready, err_valid, err_ready;
  logic in_message;
  logic [7:0] rx_byte;
  logic [3:0] hdr_min_par, hdr_max_par, par_count;
  logic [5:0] hdr_types_ok;
  logic [15:0] err_code;
  int err_count, n_tests, i, j, k;
  string s;
  cpe_row_t rows [25];
  cpe_classifier u_dut (.*);
  cpe_ctrl_model u_ctrl (.*);
  task check_code(input logic [15:0] exp);
    int t;
    t = 0;
    while (err_valid !== 1'h1 && t < 50) begin
      @(negedge sys_clk);
      t++;
    end
    n_tests++;
    if (err_valid !== 1'h1 || err_code !== exp) begin
      err_count++;
      $display("unexpected code at %0t: got %h want %h", $time, err_code, exp);
    end
    err_ready = 1'h1;
    @(negedge sys_clk);
    err_ready = 1'h0;
  endtask
  task check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected flag at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task check_cnt(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected count at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    err_count++;
    wrap_up;
  end
  initial begin
    rows = '{'{"*XYZ 1\n", 1'h0, 6'h02, 1'h0, 16'hFF8F},
      '{"*ESE 36,1\n", 1'h1, 6'h02, 1'h0, 16'hFF94},
      '{"*ESE\n", 1'h1, 6'h02, 1'h0, 16'hFF93},
      '{"ABCDEFGHIJKLM 1\n", 1'h1, 6'h02, 1'h0, 16'hFF90},
      '{"F:;A\n", 1'h1, 6'h02, 1'h0, 16'hFF99},
      '{"A::B 1\n", 1'h1, 6'h02, 1'h0, 16'hFF92},
      '{"A \"x\"\n", 1'h1, 6'h02, 1'h0, 16'hFF62},
      '{"A #15abcde\n", 1'h1, 6'h02, 1'h0, 16'hFF58},
      '{"A (1)\n", 1'h1, 6'h02, 1'h0, 16'hFF98},
      '{"A 1\n", 1'h1, 6'h04, 1'h0, 16'hFF80},
      '{"A X\n", 1'h1, 6'h02, 1'h0, 16'hFF6C},
      '{"A 1E40000\n", 1'h1, 6'h02, 1'h0, 16'hFF85},
      '{"A 1MHZZZZZZZZZZZ\n", 1'h1, 6'h02, 1'h1, 16'hFF7A},
      '{"A 1MHZ\n", 1'h1, 6'h02, 1'h0, 16'hFF76},
      '{"A ABCDFGHIJKLMN\n", 1'h1, 6'h04, 1'h0, 16'hFF70},
      '{"A \"ab", 1'h1, 6'h08, 1'h0, 16'hFF69},
      '{"A #15ab", 1'h1, 6'h10, 1'h0, 16'hFF5F},
      '{"A (1\n", 1'h1, 6'h20, 1'h0, 16'hFF55},
      '{"A 1!\n", 1'h1, 6'h02, 1'h0, 16'hFF87},
      '{"!A\n", 1'h1, 6'h02, 1'h0, 16'hFF8E},
      '{"A!\n", 1'h1, 6'h02, 1'h0, 16'hFF91},
      '{"A 1 M!\n", 1'h1, 6'h02, 1'h1, 16'hFF7D},
      '{"A X!\n", 1'h1, 6'h04, 1'h0, 16'hFF73},
      '{"A !\n", 1'h1, 6'h02, 1'h0, 16'hFF9A},
      '{"A (1\001)\n", 1'h1, 6'h20, 1'h0, 16'hFF9B}};
    err_count = 0;
    n_tests = 0;
    resetn = 1'h0;
    trig_in = 1'h0;
    parse_fault = 1'h0;
    err_ready = 1'h0;
    hdr_defined = 1'h1;
    hdr_min_par = 4'h1;
    hdr_max_par = 4'h1;
    hdr_types_ok = 6'h02;
    hdr_suffix_ok = 1'h0;
    repeat (6) @(negedge sys_clk);
    check_bit(in_message, 1'h0);
    check_bit(err_valid, 1'h0);
    resetn = 1'h1;
    for (i = 0; i < 25; i++) begin
      hdr_defined = rows[i].d;
      hdr_types_ok = rows[i].ty;
      hdr_suffix_ok = rows[i].s;
      u_ctrl.send_msg(rows[i].m, 1'h1);
      check_code(rows[i].c);
    end
    hdr_types_ok = 6'h02;
    u_ctrl.send_msg("*E", 1'h0);
    check_bit(in_message, 1'h1);
    @(negedge sys_clk);
    trig_in = 1'h1;
    @(negedge sys_clk);
    trig_in = 1'h0;
    check_code(16'hFF97);
    u_ctrl.send_msg(" 1", 1'h0);
    check_cnt(par_count, 4'h1);
    u_ctrl.send_msg("\n", 1'h1);
    check_bit(in_message, 1'h0);
    check_cnt(par_count, 4'h0);
    // Let the last byte age out of the fault assertion's window.
    @(negedge sys_clk);
    parse_fault = 1'h1;
    @(negedge sys_clk);
    parse_fault = 1'h0;
    check_code(16'hFF9C);
    // Leading zeros must not count towards the mantissa limit.
    s = "A 00";
    for (k = 0; k < 255; k++) s = {s, "7"};
    u_ctrl.send_msg({s, "\n"}, 1'h1);
    repeat (3) @(negedge sys_clk);
    check_bit(err_valid, 1'h0);
    u_ctrl.send_msg({s, "7\n"}, 1'h1);
    check_code(16'hFF84);
    // Alternating codes with no pops fill the queue and show the order.
    fork
      for (j = 0; j < 9; j++) begin
        u_ctrl.send_msg("*ESE\n", 1'h1);
        u_ctrl.send_msg("*ESE 1,2\n", 1'h1);
      end
    join_none
    k = 0;
    while (rx_ready !== 1'h0 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    check_bit(rx_ready, 1'h0);
    for (i = 0; i < 18; i++) check_code(i % 2 ? 16'hFF94 : 16'hFF93);
    wait fork;
    repeat (3) @(negedge sys_clk);
    check_bit(err_valid, 1'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
